// file: logic/cild_consts.svh
// numeric constants for the instruction length decoder
`ifndef CILD_CONSTS_SVH
`define CILD_CONSTS_SVH

`define CILD_LEN_NONE  3'h0
`define CILD_LEN_SHORT 3'h2
`define CILD_LEN_LONG  3'h4
`define CILD_CNT_ZERO  2'h0
`define CILD_CNT_ONE   2'h1
`define CILD_TRAP_ZERO 7'h00

`endif

// file: logic/cild_decoder.sv
// instruction classification and length decoding for the core tail group
// How it works
// - rotate left/right word register, two bytes
// - sign-filling right shift, two bytes
// - word/byte move, two or four bytes
// - byte-to-word move, sign or zero extend
// - conditional jumps, four bytes, taken when true
// - segment jump loads segment and target always
// - jump if bit set, optionally clear bit
// - jump if bit clear, optionally set bit
// - conditional call saves return when taken
// - segment call saves segment and return address
// - push register then absolute call, four bytes
// - trap enters routine by immediate number
// - push or pop word register, two bytes
// - context switch saves then overwrites register
// - near return, optionally pops a register
// - far return restores segment and address
// - interrupt return restores interrupted context
// - power-down decodes legal, does nothing
// - page/segment prefixes override following instructions
// - accumulator load/store decoded as four bytes
`timescale 1ns/1ns
`default_nettype none
`include "cild_consts.svh"

module cild_decoder
(
	input  wire logic                 clock,
	input  wire logic                 rstn,
	input  wire cild_pkg::cild_fetch_s fetch,
	output logic                      dec_valid_reg,
	output logic [2:0]                dec_len_reg,
	output logic                      dec_illegal_reg,
	output cild_pkg::cild_exec_s      exec_reg,
	output cild_pkg::cild_ovr_s       ovr_reg
);

	// *************************************************************
	// length choice shared by the two-form classes
	// *************************************************************
	function automatic logic [2:0] pick_len(input logic long_form);
		pick_len = long_form ? `CILD_LEN_LONG : `CILD_LEN_SHORT;
	endfunction

	cild_pkg::cild_exec_s exec_next;
	logic [2:0]           len_next;
	logic                 illegal_next;
	logic                 is_prefix;
	cild_pkg::cild_seq_e  seq_reg;
	cild_pkg::cild_seq_e  seq_next;
	logic [1:0]           remain_reg;
	logic [1:0]           remain_next;
	logic                 ext_reg_reg;

	// *************************************************************
	// classification
	// *************************************************************
	always_comb
	begin
		exec_next    = '0;
		len_next     = `CILD_LEN_NONE;
		illegal_next = 1'b0;
		is_prefix    = 1'b0;
		case (fetch.op)
			cild_pkg::CILD_OP_ROTATE:
			begin
				len_next                = `CILD_LEN_SHORT;
				exec_next.rotate_word   = 1'b1;
				exec_next.rotate_left   = fetch.variant;
			end
			cild_pkg::CILD_OP_SIGN_SHIFT:
			begin
				len_next                   = `CILD_LEN_SHORT;
				exec_next.sign_shift_right = 1'b1;
			end
			cild_pkg::CILD_OP_MOVE:
			begin
				len_next                 = pick_len(fetch.long_form);
				exec_next.move_word_byte = 1'b1;
				exec_next.move_byte      = fetch.variant;
			end
			cild_pkg::CILD_OP_MOVE_EXT:
			begin
				len_next                   = pick_len(fetch.long_form);
				exec_next.move_extend_byte = 1'b1;
				exec_next.sign_extend      = fetch.variant;
			end
			cild_pkg::CILD_OP_COND_JUMP:
			begin
				len_next             = `CILD_LEN_LONG;
				exec_next.jump_taken = fetch.cond_true;
			end
			cild_pkg::CILD_OP_SEG_JUMP:
			begin
				len_next               = `CILD_LEN_LONG;
				exec_next.jump_taken   = 1'b1;
				exec_next.segment_load = 1'b1;
			end
			cild_pkg::CILD_OP_JB_SET:
			begin
				len_next             = `CILD_LEN_LONG;
				exec_next.jump_taken = fetch.bit_value;
				exec_next.bit_clear  = fetch.variant & fetch.bit_value;
			end
			cild_pkg::CILD_OP_JB_CLEAR:
			begin
				len_next             = `CILD_LEN_LONG;
				exec_next.jump_taken = ~fetch.bit_value;
				exec_next.bit_set    = fetch.variant & ~fetch.bit_value;
			end
			cild_pkg::CILD_OP_COND_CALL:
			begin
				len_next              = `CILD_LEN_LONG;
				exec_next.call_taken  = fetch.cond_true;
				exec_next.save_return = fetch.cond_true;
			end
			cild_pkg::CILD_OP_SEG_CALL:
			begin
				len_next               = `CILD_LEN_LONG;
				exec_next.call_taken   = 1'b1;
				exec_next.save_return  = 1'b1;
				exec_next.save_segment = 1'b1;
				exec_next.segment_load = 1'b1;
			end
			cild_pkg::CILD_OP_PUSH_CALL:
			begin
				len_next              = `CILD_LEN_LONG;
				exec_next.push        = 1'b1;
				exec_next.call_taken  = 1'b1;
				exec_next.save_return = 1'b1;
			end
			cild_pkg::CILD_OP_TRAP:
			begin
				len_next           = `CILD_LEN_SHORT;
				exec_next.trap     = 1'b1;
				exec_next.trap_num = fetch.trap_num;
			end
			cild_pkg::CILD_OP_PUSH_POP:
			begin
				len_next       = `CILD_LEN_SHORT;
				exec_next.push = ~fetch.variant;
				exec_next.pop  = fetch.variant;
			end
			cild_pkg::CILD_OP_CTX_SWITCH:
			begin
				len_next                 = `CILD_LEN_LONG;
				exec_next.push           = 1'b1;
				exec_next.context_switch = 1'b1;
			end
			cild_pkg::CILD_OP_NEAR_RET:
			begin
				len_next              = `CILD_LEN_SHORT;
				exec_next.near_return = 1'b1;
				exec_next.restore_reg = fetch.variant;
			end
			cild_pkg::CILD_OP_FAR_RET:
			begin
				len_next             = `CILD_LEN_SHORT;
				exec_next.far_return = 1'b1;
			end
			cild_pkg::CILD_OP_INT_RET:
			begin
				len_next                   = `CILD_LEN_SHORT;
				exec_next.interrupt_return = 1'b1;
			end
			// newer power control made this opcode obsolete; keep it legal
			cild_pkg::CILD_OP_POWER_DOWN:
				len_next = `CILD_LEN_LONG;
			cild_pkg::CILD_OP_SOFT_RESET:
			begin
				len_next             = `CILD_LEN_LONG;
				exec_next.soft_reset = 1'b1;
			end
			cild_pkg::CILD_OP_IDLE:
			begin
				len_next             = `CILD_LEN_LONG;
				exec_next.idle_enter = 1'b1;
			end
			cild_pkg::CILD_OP_WDT_SERVICE:
			begin
				len_next                   = `CILD_LEN_LONG;
				exec_next.watchdog_service = 1'b1;
			end
			cild_pkg::CILD_OP_WDT_TOGGLE:
			begin
				len_next                   = `CILD_LEN_LONG;
				exec_next.watchdog_disable = ~fetch.variant;
				exec_next.watchdog_enable  = fetch.variant;
			end
			cild_pkg::CILD_OP_INIT_LOCK:
			begin
				len_next            = `CILD_LEN_LONG;
				exec_next.init_lock = 1'b1;
			end
			cild_pkg::CILD_OP_PAGE_PREFIX, cild_pkg::CILD_OP_SEG_PREFIX:
			begin
				len_next  = pick_len(fetch.long_form);
				is_prefix = 1'b1;
			end
			cild_pkg::CILD_OP_MAC_LDST:
			begin
				len_next                 = `CILD_LEN_LONG;
				exec_next.mac_load_store = 1'b1;
			end
			default:
				illegal_next = 1'b1;
		endcase
	end

	// *************************************************************
	// override sequence tracking
	// *************************************************************
	// a new prefix restarts the sequence; seq_count holds count minus one
	always_comb
	begin
		seq_next    = seq_reg;
		remain_next = remain_reg;
		if (fetch.valid && is_prefix)
		begin
			seq_next    = (fetch.op == cild_pkg::CILD_OP_PAGE_PREFIX) ? cild_pkg::CILD_SEQ_PAGE
			                                                          : cild_pkg::CILD_SEQ_SEG;
			remain_next = fetch.seq_count;
		end
		else if (fetch.valid && !illegal_next && seq_reg != cild_pkg::CILD_SEQ_IDLE)
		begin
			if (remain_reg == `CILD_CNT_ZERO)
				seq_next = cild_pkg::CILD_SEQ_IDLE;
			else
				remain_next = remain_reg - `CILD_CNT_ONE;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			seq_reg     <= cild_pkg::CILD_SEQ_IDLE;
			remain_reg  <= `CILD_CNT_ZERO;
			ext_reg_reg <= 1'b0;
		end
		else
		begin
			seq_reg    <= seq_next;
			remain_reg <= remain_next;
			if (fetch.valid && is_prefix)
				ext_reg_reg <= fetch.ext_reg;
		end
	end

	// *************************************************************
	// registered outputs
	// *************************************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			dec_valid_reg   <= 1'b0;
			dec_len_reg     <= `CILD_LEN_NONE;
			dec_illegal_reg <= 1'b0;
			exec_reg        <= '0;
		end
		else
		begin
			dec_valid_reg   <= fetch.valid;
			dec_len_reg     <= fetch.valid ? len_next : `CILD_LEN_NONE;
			dec_illegal_reg <= fetch.valid & illegal_next;
			exec_reg        <= fetch.valid ? exec_next : '0;
		end
	end

	// the override applies only to the instructions after the prefix
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			ovr_reg <= '0;
		else if (fetch.valid && !is_prefix && !illegal_next)
		begin
			ovr_reg.page    <= (seq_reg == cild_pkg::CILD_SEQ_PAGE);
			ovr_reg.segment <= (seq_reg == cild_pkg::CILD_SEQ_SEG);
			ovr_reg.ext_reg <= (seq_reg != cild_pkg::CILD_SEQ_IDLE) & ext_reg_reg;
		end
		else
			ovr_reg <= '0;
	end

	// *************************************************************
	// checks
	// *************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	AST_ROTATE: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_ROTATE |=>
		dec_len_reg == `CILD_LEN_SHORT && exec_reg.rotate_word && exec_reg.rotate_left == $past(fetch.variant))
		else $error("rotate decode wrong");
	AST_SIGN_SHIFT: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_SIGN_SHIFT |=>
		dec_len_reg == `CILD_LEN_SHORT && exec_reg.sign_shift_right) else $error("sign shift decode wrong");
	AST_MOVE_LEN: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_MOVE && fetch.long_form |=>
		dec_len_reg == `CILD_LEN_LONG && exec_reg.move_word_byte) else $error("long move length wrong");
	AST_EXTEND: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_MOVE_EXT |=>
		exec_reg.sign_extend == $past(fetch.variant) && dec_len_reg == pick_len($past(fetch.long_form)))
		else $error("extend move wrong");
	AST_COND_JUMP: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_COND_JUMP |=>
		dec_len_reg == `CILD_LEN_LONG && exec_reg.jump_taken == $past(fetch.cond_true))
		else $error("conditional jump wrong");
	AST_SEG_JUMP: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_SEG_JUMP |=>
		exec_reg.jump_taken && exec_reg.segment_load) else $error("segment jump wrong");
	AST_BIT_CLEAR_SIDE: assert property (exec_reg.bit_clear |-> exec_reg.jump_taken &&
		$past(fetch.op) == cild_pkg::CILD_OP_JB_SET && $past(fetch.bit_value))
		else $error("bit clear without taken set-bit jump");
	AST_BIT_SET_SIDE: assert property (exec_reg.bit_set |-> exec_reg.jump_taken &&
		$past(fetch.op) == cild_pkg::CILD_OP_JB_CLEAR && !$past(fetch.bit_value))
		else $error("bit set without taken clear-bit jump");
	AST_CALL: assert property (exec_reg.call_taken |-> exec_reg.save_return &&
		dec_len_reg == `CILD_LEN_LONG) else $error("call without saved return");
	AST_TRAP: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_TRAP |=>
		exec_reg.trap && exec_reg.trap_num == $past(fetch.trap_num) && dec_len_reg == `CILD_LEN_SHORT)
		else $error("trap decode wrong");
	AST_POWER_DOWN: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_POWER_DOWN |=>
		dec_len_reg == `CILD_LEN_LONG && !dec_illegal_reg && exec_reg == '0)
		else $error("power-down opcode not a silent no-op");
	AST_PREFIX_OVR: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_PAGE_PREFIX
		##1 fetch.valid && !is_prefix && !illegal_next |=> ovr_reg.page && !ovr_reg.segment)
		else $error("page override not applied");
	AST_MAC: assert property (fetch.valid && fetch.op == cild_pkg::CILD_OP_MAC_LDST |=>
		dec_len_reg == `CILD_LEN_LONG && exec_reg.mac_load_store) else $error("accumulator transfer wrong");
	AST_SYS_STROBE: assert property (exec_reg.soft_reset || exec_reg.init_lock || exec_reg.watchdog_service |->
		dec_len_reg == `CILD_LEN_LONG && $past(fetch.valid)) else $error("system strobe wrong");

	COV_TAKEN_BIT_CLEAR: cover property (exec_reg.bit_clear);
	COV_ILLEGAL: cover property (dec_illegal_reg);
	COV_SEG_OVR_TWO: cover property (ovr_reg.segment ##1 ovr_reg.segment);
	COV_CALL_SKIPPED: cover property (fetch.valid && fetch.op == cild_pkg::CILD_OP_COND_CALL && !fetch.cond_true);

endmodule
`default_nettype wire

// file: logic/cild_pkg.sv
// types shared by the instruction length decoder
`default_nettype none
package cild_pkg;

	// instruction classes as presented by the fetch path
	typedef enum logic [4:0] {
		CILD_OP_INVALID     = 5'h00,
		CILD_OP_ROTATE      = 5'h01,
		CILD_OP_SIGN_SHIFT  = 5'h02,
		CILD_OP_MOVE        = 5'h03,
		CILD_OP_MOVE_EXT    = 5'h04,
		CILD_OP_COND_JUMP   = 5'h05,
		CILD_OP_SEG_JUMP    = 5'h06,
		CILD_OP_JB_SET      = 5'h07,
		CILD_OP_JB_CLEAR    = 5'h08,
		CILD_OP_COND_CALL   = 5'h09,
		CILD_OP_SEG_CALL    = 5'h0a,
		CILD_OP_PUSH_CALL   = 5'h0b,
		CILD_OP_TRAP        = 5'h0c,
		CILD_OP_PUSH_POP    = 5'h0d,
		CILD_OP_CTX_SWITCH  = 5'h0e,
		CILD_OP_NEAR_RET    = 5'h0f,
		CILD_OP_FAR_RET     = 5'h10,
		CILD_OP_INT_RET     = 5'h11,
		CILD_OP_POWER_DOWN  = 5'h12,
		CILD_OP_SOFT_RESET  = 5'h13,
		CILD_OP_IDLE        = 5'h14,
		CILD_OP_WDT_SERVICE = 5'h15,
		CILD_OP_WDT_TOGGLE  = 5'h16,
		CILD_OP_INIT_LOCK   = 5'h17,
		CILD_OP_PAGE_PREFIX = 5'h18,
		CILD_OP_SEG_PREFIX  = 5'h19,
		CILD_OP_MAC_LDST    = 5'h1a
	} cild_op_e;

	// one fetched instruction, already classified
	typedef struct packed {
		logic       valid;
		cild_op_e   op;
		logic       long_form;
		logic       variant;
		logic       cond_true;
		logic       bit_value;
		logic       ext_reg;
		logic [1:0] seq_count;
		logic [6:0] trap_num;
	} cild_fetch_s;

	// strobes to the execution units
	typedef struct packed {
		logic       rotate_word;
		logic       rotate_left;
		logic       sign_shift_right;
		logic       move_word_byte;
		logic       move_byte;
		logic       move_extend_byte;
		logic       sign_extend;
		logic       jump_taken;
		logic       segment_load;
		logic       bit_clear;
		logic       bit_set;
		logic       call_taken;
		logic       save_return;
		logic       save_segment;
		logic       push;
		logic       pop;
		logic       trap;
		logic [6:0] trap_num;
		logic       context_switch;
		logic       near_return;
		logic       restore_reg;
		logic       far_return;
		logic       interrupt_return;
		logic       soft_reset;
		logic       idle_enter;
		logic       watchdog_service;
		logic       watchdog_disable;
		logic       watchdog_enable;
		logic       init_lock;
		logic       mac_load_store;
	} cild_exec_s;

	// data addressing override seen by the following instructions
	typedef struct packed {
		logic page;
		logic segment;
		logic ext_reg;
	} cild_ovr_s;

	typedef enum logic [1:0] {
		CILD_SEQ_IDLE = 2'b00,
		CILD_SEQ_PAGE = 2'b01,
		CILD_SEQ_SEG  = 2'b10
	} cild_seq_e;

endpackage
`default_nettype wire

// file: test/cild_fetch_model.sv
// fetch path model that presents classified instructions to the decoder
`timescale 1ns/1ns
`default_nettype none

module cild_fetch_model
(
	input  wire logic             clock,
	output var cild_pkg::cild_fetch_s fetch
);
	initial fetch = '0;

	// one instruction per falling edge, held until the next call
	task automatic present(input cild_pkg::cild_fetch_s f);
	begin
		@(negedge clock);
		fetch <= f;
	end
	endtask

	// idle fields are inverted so a stale instruction never looks current
	task automatic idle();
		cild_pkg::cild_fetch_s t;
	begin
		@(negedge clock);
		t = ~fetch;
		t.valid = 1'b0;
		fetch <= t;
	end
	endtask
endmodule

`default_nettype wire

// file: test/tb_cpu_instruction_length_decoder.sv
// self-checking bench for the instruction length decoder
`timescale 1ns/1ns
`default_nettype none
`include "cild_consts.svh"

module tb_cpu_instruction_length_decoder;
	typedef struct packed {
		logic                 v;
		logic [2:0]           len;
		logic                 ill;
		cild_pkg::cild_exec_s e;
		cild_pkg::cild_ovr_s  o;
	} cild_res_s;

	logic                  clock = 1'b0;
	logic                  rstn  = 1'b0;
	cild_pkg::cild_fetch_s fetch;
	cild_res_s             seen;
	cild_res_s             expq[$];
	cild_pkg::cild_ovr_s   ovr_hold = '0;
	int                    seq_left = 0;
	int                    seed = 97229;
	int                    err_count = 0;
	int                    n_tests = 0;

	always #50 clock = ~clock;

	cild_fetch_model i_fetch (.clock(clock), .fetch(fetch));

	cild_decoder i_dut
	(
		.clock(clock),
		.rstn(rstn),
		.fetch(fetch),
		.dec_valid_reg(seen.v),
		.dec_len_reg(seen.len),
		.dec_illegal_reg(seen.ill),
		.exec_reg(seen.e),
		.ovr_reg(seen.o)
	);

	// ************************************************************
	// comparison and verdict
	// ************************************************************
	task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	end
	endtask

	task automatic close_out();
	begin
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// ************************************************************
	// reference decode, noted before the instruction is presented
	// ************************************************************
	task automatic issue(input cild_pkg::cild_fetch_s f);
		cild_res_s  r;
		logic [2:0] lv;
	begin
		r = '0;
		r.v = 1'b1;
		r.len = `CILD_LEN_LONG;
		lv = f.long_form ? `CILD_LEN_LONG : `CILD_LEN_SHORT;
		case (f.op)
			cild_pkg::CILD_OP_ROTATE:      {r.e.rotate_word, r.e.rotate_left, r.len} = {1'b1, f.variant, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_SIGN_SHIFT:  {r.e.sign_shift_right, r.len} = {1'b1, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_MOVE:        {r.e.move_word_byte, r.e.move_byte, r.len} = {1'b1, f.variant, lv};
			cild_pkg::CILD_OP_MOVE_EXT:    {r.e.move_extend_byte, r.e.sign_extend, r.len} = {1'b1, f.variant, lv};
			cild_pkg::CILD_OP_COND_JUMP:   r.e.jump_taken = f.cond_true;
			cild_pkg::CILD_OP_SEG_JUMP:    {r.e.jump_taken, r.e.segment_load} = 2'h3;
			cild_pkg::CILD_OP_JB_SET:      {r.e.jump_taken, r.e.bit_clear} = {f.bit_value, f.bit_value & f.variant};
			cild_pkg::CILD_OP_JB_CLEAR:    {r.e.jump_taken, r.e.bit_set} = {!f.bit_value, !f.bit_value & f.variant};
			cild_pkg::CILD_OP_COND_CALL:   {r.e.call_taken, r.e.save_return} = {2{f.cond_true}};
			cild_pkg::CILD_OP_SEG_CALL:    {r.e.call_taken, r.e.save_return, r.e.save_segment, r.e.segment_load} = 4'hf;
			cild_pkg::CILD_OP_PUSH_CALL:   {r.e.push, r.e.call_taken, r.e.save_return} = 3'h7;
			cild_pkg::CILD_OP_TRAP:        {r.e.trap, r.e.trap_num, r.len} = {1'b1, f.trap_num, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_PUSH_POP:    {r.e.push, r.e.pop, r.len} = {!f.variant, f.variant, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_CTX_SWITCH:  {r.e.push, r.e.context_switch} = 2'h3;
			cild_pkg::CILD_OP_NEAR_RET:    {r.e.near_return, r.e.restore_reg, r.len} = {1'b1, f.variant, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_FAR_RET:     {r.e.far_return, r.len} = {1'b1, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_INT_RET:     {r.e.interrupt_return, r.len} = {1'b1, `CILD_LEN_SHORT};
			cild_pkg::CILD_OP_POWER_DOWN:  r.len = `CILD_LEN_LONG;
			cild_pkg::CILD_OP_SOFT_RESET:  r.e.soft_reset = 1'b1;
			cild_pkg::CILD_OP_IDLE:        r.e.idle_enter = 1'b1;
			cild_pkg::CILD_OP_WDT_SERVICE: r.e.watchdog_service = 1'b1;
			cild_pkg::CILD_OP_WDT_TOGGLE:  {r.e.watchdog_disable, r.e.watchdog_enable} = {!f.variant, f.variant};
			cild_pkg::CILD_OP_INIT_LOCK:   r.e.init_lock = 1'b1;
			cild_pkg::CILD_OP_PAGE_PREFIX: r.len = lv;
			cild_pkg::CILD_OP_SEG_PREFIX:  r.len = lv;
			cild_pkg::CILD_OP_MAC_LDST:    r.e.mac_load_store = 1'b1;
			default:                       {r.ill, r.len} = {1'b1, `CILD_LEN_NONE};
		endcase
		// illegal classes and idle slots never touch the override count
		if (f.valid && f.op inside {cild_pkg::CILD_OP_PAGE_PREFIX, cild_pkg::CILD_OP_SEG_PREFIX})
		begin
			seq_left = int'(f.seq_count) + 1;
			ovr_hold = {f.op == cild_pkg::CILD_OP_PAGE_PREFIX, f.op == cild_pkg::CILD_OP_SEG_PREFIX, f.ext_reg};
		end
		else if (f.valid && !r.ill && seq_left != 0)
		begin
			r.o = ovr_hold;
			seq_left--;
		end
		if (f.valid)
			expq.push_back(r);
		i_fetch.present(f);
	end
	endtask

	function automatic cild_pkg::cild_fetch_s mk(input cild_pkg::cild_op_e op, input logic [1:0] cnt, input logic ext);
		cild_pkg::cild_fetch_s f;
	begin
		f = '0;
		{f.valid, f.op, f.seq_count, f.ext_reg} = {1'b1, op, cnt, ext};
		return f;
	end
	endfunction

	// ************************************************************
	// output monitor: idle cycles must show all zero
	// ************************************************************
	always @(negedge clock)
	begin
		cild_res_s exp;
		exp = '0;
		if (seen.v === 1'b1 && expq.size() > 0)
			exp = expq.pop_front();
		check("valid", 64'(seen.v), 64'(exp.v));
		check("length", 64'(seen.len), 64'(exp.len));
		check("illegal", 64'(seen.ill), 64'(exp.ill));
		check("strobes", 64'(seen.e), 64'(exp.e));
		check("override", 64'(seen.o), 64'(exp.o));
	end

	initial
	begin
		#600000;
		err_count++;
		close_out();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		cild_pkg::cild_fetch_s f;
		repeat (8) @(negedge clock);
		rstn <= 1'b1;
		// every class code with every variant and form, back to back
		for (int k = 0; k < 128; k++)
		begin
			f = cild_pkg::cild_fetch_s'(20'($random(seed)));
			f.valid = 1'b1;
			f.op = cild_pkg::cild_op_e'(k[6:2]);
			{f.variant, f.long_form} = k[1:0];
			issue(f);
		end
		// override sequence across an illegal class and an idle gap
		issue(mk(cild_pkg::CILD_OP_PAGE_PREFIX, 2'h1, 1'b1));
		issue(mk(cild_pkg::CILD_OP_MOVE, 2'h0, 1'b0));
		issue(mk(cild_pkg::CILD_OP_INVALID, 2'h0, 1'b0));
		i_fetch.idle();
		issue(mk(cild_pkg::CILD_OP_MOVE, 2'h0, 1'b0));
		issue(mk(cild_pkg::CILD_OP_MOVE, 2'h0, 1'b0));
		issue(mk(cild_pkg::CILD_OP_SEG_PREFIX, 2'h3, 1'b0));
		issue(mk(cild_pkg::CILD_OP_ROTATE, 2'h0, 1'b0));
		issue(mk(cild_pkg::CILD_OP_PAGE_PREFIX, 2'h0, 1'b0));
		issue(mk(cild_pkg::CILD_OP_SEG_PREFIX, 2'h3, 1'b1));
		issue(mk(cild_pkg::CILD_OP_ROTATE, 2'h0, 1'b0));
		i_fetch.idle();
		// reset in mid sequence drops the pending override
		@(negedge clock);
		rstn <= 1'b0;
		repeat (2) @(negedge clock);
		rstn <= 1'b1;
		seq_left = 0;
		issue(mk(cild_pkg::CILD_OP_MOVE, 2'h0, 1'b0));
		for (int k = 0; k < 3000; k++)
			issue(cild_pkg::cild_fetch_s'(20'($random(seed))));
		i_fetch.idle();
		repeat (4) @(negedge clock);
		check("queue", 64'(expq.size()), 64'h0);
		close_out();
	end
endmodule

`default_nettype wire
